// File: rtl/dac_port_pkg.sv
// constants for the three-wire converter write port
// assumes a single 20 MHz system clock samples all link pins
package dac_port_pkg;
    localparam int          FRAME_BITS      = 16;        // shift register length
    localparam int          CODE_BITS       = 12;        // converter code width
    localparam int          MODE_POS        = 14;        // lsb of mode field
    localparam int          CODE_POS        = 2;         // lsb of code field
    localparam logic [11:0] CODE_RESET      = 12'h000;   // code after reset
    localparam logic [1:0]  MODE_RESET      = 2'h0;      // normal operation after reset
    localparam int          CLK_PERIOD_NS   = 50;        // system clock period
    localparam int          SYNC_HIGH_NS    = 33;        // least frame select high time
    localparam int          SYNC_HIGH_CYC   = (SYNC_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,    // output active
        MODE_PD_1K  = 2'h1,    // power-down, 1k pulldown
        MODE_PD_100K = 2'h2,   // power-down, 100k pulldown
        MODE_PD_TRI = 2'h3     // power-down, three-state
    } mode_t;
endpackage : dac_port_pkg

// File: rtl/dac_serial_write_port.sv
// serial write port of a single-channel converter: frame select, serial clock, data
// assumes pins are asynchronous to clk and the serial clock is far slower than clk
// Operation
// - frame select low enables the shift register
// - data sampled on serial clock falling edges
// - frame is exactly sixteen bits
// - sixteenth falling edge updates code and mode
// - early frame select rise discards frame
// - two leading bits choose operating mode
// - mode, twelve code bits, two ignored bits
// - reset clears code until valid frame
`timescale 1ns/1ps
module dac_serial_write_port
    import dac_port_pkg::*;
(
    input  wire logic                 clk,             // 20 MHz system clock
    input  wire logic                 rst,             // synchronous reset, active high
    input  wire logic                 frame_sel_n,     // frame select pin, active low
    input  wire logic                 serial_clk,      // serial clock pin
    input  wire logic                 serial_data_in,  // serial data pin
    output logic [CODE_BITS-1:0]      dac_code,        // converter code register
    output logic [1:0]                op_mode,         // operating mode bits
    output logic                      update_pulse,    // one cycle on each applied frame
    output logic                      abort_pulse      // one cycle on each discarded frame
);

    ////////////////////////////////////////////////////////////////////////
    // synchronisers
    logic [1:0] sel_sync_q;   // frame select stages
    logic [1:0] sck_sync_q;   // serial clock stages
    logic [1:0] sdi_sync_q;   // data stages
    logic       sel_q;        // delayed synced select
    logic       sck_q;        // delayed synced clock

    // two flops per pin; only stage one reads stage zero
    // select and serial clock reset to their idle high level, so that
    // leaving reset never shows a false edge to the detectors below
    always_ff @(posedge clk) begin
        if (rst) begin
            sel_sync_q <= 2'h3;
            sck_sync_q <= 2'h3;
            sdi_sync_q <= 2'h0;
            sel_q      <= 1'h1;
            sck_q      <= 1'h1;
        end else begin
            sel_sync_q <= {sel_sync_q[0], frame_sel_n};
            sck_sync_q <= {sck_sync_q[0], serial_clk};
            sdi_sync_q <= {sdi_sync_q[0], serial_data_in};
            sel_q      <= sel_sync_q[1];
            sck_q      <= sck_sync_q[1];
        end
    end

    // data travels through the same two stages as the serial clock, so the
    // bit seen at a detected fall is the one that stood at the pin edge;
    // limitation: serial clock half periods must span at least two clk periods
    logic sel_fall;   // frame start
    logic sel_rise;   // frame end
    logic sck_fall;   // data sample point
    assign sel_fall = sel_q & ~sel_sync_q[1];
    assign sel_rise = ~sel_q & sel_sync_q[1];
    assign sck_fall = sck_q & ~sck_sync_q[1];

    ////////////////////////////////////////////////////////////////////////
    // frame state
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,   // waiting for select falling edge
        ST_SHIFT = 3'h2,   // collecting bits
        ST_DONE  = 3'h4    // frame applied, extra edges ignored
    } state_t;

    state_t                 state_q;   // frame state
    logic [FRAME_BITS-1:0]  shift_q;   // input shift register
    logic [4:0]             count_q;   // bits received
    logic                   last_bit;  // sixteenth falling edge now

    assign last_bit = (state_q == ST_SHIFT) && sck_fall && !sel_sync_q[1]
                      && (count_q == 5'(FRAME_BITS - 1));

    // sequencer; a select rise wins over a clock fall in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (sel_fall) begin
                        state_q <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (sel_sync_q[1]) begin
                        state_q <= ST_IDLE;
                    end else if (last_bit) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (sel_sync_q[1]) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;   // illegal one-hot codes
            endcase
        end
    end

    // shift msb first, count edges; cleared on every frame start
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_q <= 16'h0000;
            count_q <= 5'h00;
        end else if (sel_fall) begin
            shift_q <= 16'h0000;
            count_q <= 5'h00;
        end else if (state_q == ST_SHIFT && sck_fall && !sel_sync_q[1]) begin
            shift_q <= {shift_q[FRAME_BITS-2:0], sdi_sync_q[1]};
            count_q <= count_q + 5'h01;
        end
    end

    // field layout must tile the frame: code below mode, mode at the top
    if (CODE_POS + CODE_BITS != MODE_POS || MODE_POS + 2 != FRAME_BITS) begin : g_layout_chk
        $error("field layout does not fill the frame");
    end

    logic [FRAME_BITS-1:0] word;   // completed frame including final bit
    assign word = {shift_q[FRAME_BITS-2:0], sdi_sync_q[1]};

    ////////////////////////////////////////////////////////////////////////
    // output registers
    always_ff @(posedge clk) begin
        if (rst) begin
            dac_code <= CODE_RESET;
            op_mode  <= MODE_RESET;
        end else if (last_bit) begin
            op_mode  <= word[MODE_POS +: 2];
            dac_code <= word[CODE_POS +: CODE_BITS];
        end
    end

    // event strobes
    always_ff @(posedge clk) begin
        if (rst) begin
            update_pulse <= 1'h0;
            abort_pulse  <= 1'h0;
        end else begin
            update_pulse <= last_bit;
            abort_pulse  <= (state_q == ST_SHIFT) && sel_rise;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    update_hold_a: assert property (@(posedge clk) disable iff (rst)
        !$past(last_bit) |-> !update_pulse || $past(last_bit))
        else $error("update pulse without sixteenth edge");
    update_sync_a: assert property (@(posedge clk) disable iff (rst)
        last_bit |=> update_pulse && dac_code == $past(word[13:2]))
        else $error("code not loaded on sixteenth edge");
    mode_load_a: assert property (@(posedge clk) disable iff (rst)
        last_bit |=> op_mode == $past(word[15:14]))
        else $error("mode not loaded from leading bits");
    code_stable_a: assert property (@(posedge clk) disable iff (rst)
        !$past(last_bit) |-> $stable(dac_code) && $stable(op_mode))
        else $error("code changed without complete frame");
    abort_idle_a: assert property (@(posedge clk) disable iff (rst)
        abort_pulse |-> state_q == ST_IDLE && !update_pulse)
        else $error("abort did not discard frame");
    frame_start_a: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_IDLE && !sel_fall |=> state_q == ST_IDLE)
        else $error("frame began without select fall");
    count_limit_a: assert property (@(posedge clk) disable iff (rst)
        count_q <= 5'h10)
        else $error("more than sixteen bits shifted");
    shift_edge_a: assert property (@(posedge clk) disable iff (rst)
        !sck_fall && !sel_fall |=> $stable(count_q))
        else $error("bit counted without clock fall");
    done_hold_a: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_DONE && !sel_sync_q[1] |=> state_q == ST_DONE)
        else $error("new frame without select high");
    reset_code_a: assert property (@(posedge clk)
        $past(rst) |-> dac_code == CODE_RESET && op_mode == MODE_RESET)
        else $error("reset did not clear code");

    // a frame is either applied or discarded, never both
    pulse_excl_a: assert property (@(posedge clk) disable iff (rst)
        !(update_pulse && abort_pulse))
        else $error("update and abort together");
    // strobes last a single cycle each
    update_once_a: assert property (@(posedge clk) disable iff (rst)
        update_pulse |=> !update_pulse)
        else $error("update pulse longer than one cycle");
    abort_once_a: assert property (@(posedge clk) disable iff (rst)
        abort_pulse |=> !abort_pulse)
        else $error("abort pulse longer than one cycle");
    // an early select rise while shifting must leave the frame
    sync_abort_a: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_SHIFT && sel_sync_q[1] |=> state_q == ST_IDLE)
        else $error("shifting went on after select rise");
    // outside the shift state nothing may reach the outputs
    idle_hold_a: assert property (@(posedge clk) disable iff (rst)
        state_q != ST_SHIFT |=> $stable(dac_code) && $stable(op_mode))
        else $error("outputs moved outside a frame");
    // each new frame begins with an empty bit count
    start_clear_a: assert property (@(posedge clk) disable iff (rst)
        sel_fall |=> count_q == 5'h00)
        else $error("bit count not cleared at frame start");
    // the synced data bit enters at the bottom of the shift register
    bit_sample_a: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_SHIFT && sck_fall && !sel_sync_q[1] |=> shift_q[0] == $past(sdi_sync_q[1]))
        else $error("data bit not shifted in on clock fall");

endmodule : dac_serial_write_port

// File: tb/host_serial_master.sv
// host side of the three-wire write port: frame select, serial clock, data
// assumes the bench clock is 50 ns; pins move on its falling edge
`timescale 1ns/1ps
module host_serial_master (
    input  wire logic clk,            // bench clock
    output logic      frame_sel_n,    // frame select, active low
    output logic      serial_clk,     // serial clock, idle high outside frames
    output logic      serial_data_in  // serial data
);
    localparam int HALF_CYC = 4;      // 200 ns half period, 2.5 MHz
    ////////////////////////////////////////////////////////////////////////
    // idle pins at time zero
    initial begin
        frame_sel_n    = 1'b1;
        serial_clk     = 1'b1;
        serial_data_in = 1'b0;
    end
    // one frame of n_bits edges; beyond 16 the data is junk
    task automatic send_frame(input logic [15:0] word, input int n_bits);
        @(negedge clk);
        frame_sel_n = 1'b0;
        for (int i = 0; i < n_bits; i++) begin
            serial_data_in = (i < 16) ? word[15-i] : ~word[0];
            repeat (HALF_CYC) @(negedge clk);
            serial_clk = 1'b0;
            repeat (HALF_CYC) @(negedge clk);
            serial_clk = 1'b1;
        end
        repeat (HALF_CYC) @(negedge clk);
        frame_sel_n    = 1'b1;
        serial_data_in = ~serial_data_in; // released line: no stale value
        repeat (2 * HALF_CYC) @(negedge clk);
    endtask : send_frame
endmodule : host_serial_master

// File: tb/dac_serial_write_port_tb_top.sv
// self-checking bench for the serial write port
// assumes the host model above; seed of the random source is 49
`timescale 1ns/1ps
module dac_serial_write_port_tb_top;
    import dac_port_pkg::*;
    logic                 clk, rst, frame_sel_n, serial_clk, serial_data_in;
    logic [CODE_BITS-1:0] dac_code;              // code under test
    logic [1:0]           op_mode;               // mode under test
    logic                 update_pulse, abort_pulse;
    logic [11:0]          exp_c = CODE_RESET;    // expected code
    logic [1:0]           exp_m = MODE_RESET;    // expected mode
    logic [15:0]          lfsr_q = 16'h0031;     // random state
    int                   n_mismatch = 0, checked = 0, n_upd = 0, n_abt = 0;
    ////////////////////////////////////////////////////////////////////////
    dac_serial_write_port dac_serial_write_port_inst (.clk(clk), .rst(rst),
        .frame_sel_n(frame_sel_n), .serial_clk(serial_clk), .serial_data_in(serial_data_in),
        .dac_code(dac_code), .op_mode(op_mode), .update_pulse(update_pulse), .abort_pulse(abort_pulse));
    host_serial_master host_serial_master_inst (.clk(clk), .frame_sel_n(frame_sel_n),
        .serial_clk(serial_clk), .serial_data_in(serial_data_in));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // count strobes; a missed or doubled one shows in the deltas
    always @(negedge clk) begin
        if (update_pulse === 1'b1) n_upd++;
        if (abort_pulse === 1'b1) n_abt++;
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    task automatic flag(input string msg);
        n_mismatch++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask : flag
    task automatic cmp_code(input logic [11:0] e);
        checked++;
        if (dac_code !== e) flag($sformatf("code %h want %h", dac_code, e));
    endtask : cmp_code
    task automatic cmp_mode(input logic [1:0] e);
        checked++;
        if (op_mode !== e) flag($sformatf("mode %b want %b", op_mode, e));
    endtask : cmp_mode
    task automatic cmp_count(input int g, input int e);
        checked++;
        if (g != e) flag($sformatf("strobes %0d want %0d", g, e));
    endtask : cmp_count
    // one frame, then the expected outcome from its length
    task automatic do_frame(input logic [15:0] w, input int n);
        int u0, a0;
        u0 = n_upd;
        a0 = n_abt;
        host_serial_master_inst.send_frame(w, n);
        if (n >= FRAME_BITS) begin
            exp_c = w[13:2];
            exp_m = w[15:14];
        end
        cmp_code(exp_c);
        cmp_mode(exp_m);
        cmp_count(n_upd - u0, (n >= FRAME_BITS) ? 1 : 0);
        cmp_count(n_abt - a0, (n >= FRAME_BITS) ? 0 : 1);
    endtask : do_frame
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////
    // 32 frames of ~140 cycles each; far more is a hang
    initial begin
        repeat (20000) @(posedge clk);
        flag("watchdog ran out");
        end_sim();
    end
    initial begin
        rst = 1'b1;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        cmp_code(CODE_RESET);
        cmp_mode(MODE_RESET);
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            lfsr_q = lfsr_next(lfsr_q);
            do_frame({m[1:0], lfsr_q[13:0]}, 16);
        end
        do_frame(16'hFFFF, 15);
        do_frame(16'h7FFC, 17);
        $display("test modes and corners done");
        for (int k = 0; k < 24; k++) begin
            lfsr_q = lfsr_next(lfsr_q);
            do_frame(lfsr_q, 12 + int'(lfsr_q % 16'h0006));
        end
        $display("test random frames done");
        do_frame(16'hD554, 16);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        exp_c = CODE_RESET;
        exp_m = MODE_RESET;
        repeat (3) @(negedge clk);
        cmp_code(exp_c);
        cmp_mode(exp_m);
        do_frame(16'h8AB5, 16);
        $display("test second reset done");
        end_sim();
    end
endmodule : dac_serial_write_port_tb_top
